// [design/vcrc_defines.svh]
// Purpose: Offsets, field positions, reset values and timing counts of the second channel register pair.
// Assumes: 32-bit APB data, byte addresses equal to the printed offsets.
// Notes: Definitions only.
`ifndef VCRC_DEFINES_SVH
`define VCRC_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define VCRC_CAP_OFFSET 12'h15C
`define VCRC_CTRL_OFFSET 12'h160
`define VCRC_STAT_OFFSET 12'h164
`define VCRC_TBLW_OFFSET 12'h168

// ----------------------------------------------------------------------------
// Capability fields
// ----------------------------------------------------------------------------
`define VCRC_CAP_ARB_LSB 0
`define VCRC_CAP_ASO_BIT 14
`define VCRC_CAP_SNP_BIT 15
`define VCRC_CAP_SLOT_LSB 16
`define VCRC_CAP_TOFS_LSB 24
`define VCRC_CAP_ARB_RST 8'h19
`define VCRC_CAP_SLOT_RST 7'h7F
`define VCRC_CAP_TOFS_RST 8'h08

// ----------------------------------------------------------------------------
// Control and status fields
// ----------------------------------------------------------------------------
`define VCRC_CTRL_MAP_LSB 0
`define VCRC_CTRL_LOAD_BIT 16
`define VCRC_CTRL_SEL_LSB 17
`define VCRC_CTRL_ID_LSB 24
`define VCRC_CTRL_EN_BIT 31
`define VCRC_CTRL_MAP_RST 8'h00
`define VCRC_CTRL_ID_RST 3'h1
`define VCRC_STAT_PEND_BIT 16

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define VCRC_LOAD_TIME_NS 320
`define VCRC_CLK_PERIOD_NS 20
`define VCRC_LOAD_CYCLES ((`VCRC_LOAD_TIME_NS + `VCRC_CLK_PERIOD_NS - 1) / `VCRC_CLK_PERIOD_NS)

`endif

// [design/vcrc_pkg.sv]
// Purpose: Types shared by the second channel register pair.
// Assumes: Nothing beyond the defines header.
// Notes: Holds types only.
package vcrc_pkg;

  typedef enum logic [2:0] {
    VCRC_ARB_FIXED = 3'h0,
    VCRC_ARB_WRR128 = 3'h3,
    VCRC_ARB_TWRR128 = 3'h4
  } vcrc_arb_e;

  typedef enum logic [1:0] {
    VCRC_LD_IDLE,
    VCRC_LD_BUSY
  } vcrc_load_e;

endpackage : vcrc_pkg

// [design/vcrc_sync.sv]
// Purpose: Three-stage synchroniser for a level from outside the clock domain.
// Assumes: Single clock pclk, asynchronous active-low reset.
// Notes: The output changes only once the second and third stages agree.
`timescale 1ns/10ps
module vcrc_sync (
  input wire logic pclk, // Clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic async_in, // Level from another domain.
  output logic sync_out // Filtered level.
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic out_reg;
  wire agree = (s2_reg == s3_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      out_reg <= 1'b0;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (agree) begin
        out_reg <= s3_reg;
      end
    end
  end

  assign sync_out = out_reg;
endmodule : vcrc_sync

// [design/vcrc_load_timer.sv]
// Purpose: Counts the time hardware needs to load the arbitration table.
// Assumes: start is a one-cycle pulse on pclk.
// Notes: A start while busy restarts the count.
`timescale 1ns/10ps
`include "vcrc_defines.svh"
module vcrc_load_timer #(
  parameter int CYCLES = `VCRC_LOAD_CYCLES
) (
  input wire logic pclk, // Clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic start, // Begin a table load.
  output logic busy, // Load in progress.
  output logic done // One-cycle pulse when the load completes.
);
  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cnt_reg;
  logic done_reg;
  wire last = (cnt_reg == CW'(1));

  initial begin
    if (CYCLES < 1) begin
      $error("vcrc_load_timer: CYCLES must be at least one.");
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= !start && last;
      if (start) begin
        cnt_reg <= CW'(CYCLES);
      end else if (cnt_reg != '0) begin
        cnt_reg <= cnt_reg - CW'(1);
      end
    end
  end

  assign busy = (cnt_reg != '0);
  assign done = done_reg;
endmodule : vcrc_load_timer

// [design/vcrc_regs.sv]
// Purpose: APB register pair for the second virtual channel resource: capability and control.
// Assumes: pclk at 50 MHz, presetn asynchronous active low, strap level from a pin.
// Notes: Zero wait states; unmapped addresses read zero and answer with pslverr.
//
// Overview of operation
// - Capability bits 7:0 read 19h when strapped, else 00h; read-only.
// - Arbiter offers fixed round robin, 128-phase weighted and time-based weighted schemes.
// - Capability bit 14 is read-only and always reads zero.
// - Capability bit 15 is read-only and always reads zero.
// - Bits 22:16 give time slots minus one: 7Fh strapped, else 00h; autoload overrides when strapped.
// - Bits 31:24 give table offset in 16-byte units: 08h strapped, else 00h.
// - Each map bit maps one traffic class here; resets 00h; autoload overrides.
// - Map bit 0 is read-only zero; writes to it do nothing.
// - Writing one to load bit applies the table; bit reads zero.
// - Select accepts 000b, 011b, 100b; other written values act as 000b.
// - Channel identifier is writable; resets 001b when strapped, else 000b.
// - Enable bit switches this channel on; writable only when strapped, resets to zero.
// - Control layout: map 7:0, load 16, select 19:17, id 26:24, enable 31.
// - Pending flag set by table writes, cleared when the table load completes.
//
// The APB register port was left to the implementer.
`timescale 1ns/10ps
`include "vcrc_defines.svh"
module vcrc_regs #(
  parameter int ADDR_W = 12,
  parameter int LOAD_CYCLES = `VCRC_LOAD_CYCLES
) (
  input wire logic pclk, // Core clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB access phase.
  input wire logic pwrite, // APB direction, high for write.
  input wire logic [ADDR_W-1:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  input wire logic [3:0] pstrb, // APB byte strobes.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error on unmapped address.
  input wire logic strap_present, // Strap level enabling the second channel.
  input wire logic autoload_valid, // Pulse: EEPROM autoload values valid.
  input wire logic [6:0] autoload_slots, // Autoloaded time-slot count minus one.
  input wire logic [7:0] autoload_map, // Autoloaded traffic class map.
  input wire logic table_write, // Pulse: an arbitration table entry was written.
  output logic [7:0] traffic_class_map, // Traffic classes mapped to this channel.
  output vcrc_pkg::vcrc_arb_e arb_scheme, // Effective arbitration scheme.
  output logic [2:0] channel_id, // Channel identifier.
  output logic channel_enable, // Channel enabled.
  output logic table_apply, // Pulse: apply programmed table.
  output logic table_loading, // Table load in progress.
  output logic table_pending // Table written but not yet loaded.
);

  // --------------------------------------------------------------------------
  // Elaboration checks
  // --------------------------------------------------------------------------
  initial begin
    if (ADDR_W < 9) begin
      $error("vcrc_regs: ADDR_W too small for the register offsets.");
    end
    if (LOAD_CYCLES < 1) begin
      $error("vcrc_regs: LOAD_CYCLES must be at least one.");
    end
  end

  // --------------------------------------------------------------------------
  // Strap capture
  // --------------------------------------------------------------------------
  logic strap_sync;
  logic strap_reg;
  logic strap_taken_reg;

  vcrc_sync u_strap_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(strap_present),
    .sync_out(strap_sync)
  );

  // The strap is caught once after reset so later pin glitches cannot change reset values.
  // The wait outlasts the synchroniser's four-edge latency, so the settled level is taken.
  logic [2:0] settle_reg;
  wire settle_done = (settle_reg == 3'h7);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_reg <= 2'h0;
      strap_reg <= 1'b0;
      strap_taken_reg <= 1'b0;
    end else begin
      if (!settle_done) begin
        settle_reg <= settle_reg + 3'h1;
      end
      if (settle_done && !strap_taken_reg) begin
        strap_reg <= strap_sync;
        strap_taken_reg <= 1'b1;
      end
    end
  end

  wire strap_capture = settle_done && !strap_taken_reg;

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  wire [ADDR_W-1:0] cap_addr = ADDR_W'(`VCRC_CAP_OFFSET);
  wire [ADDR_W-1:0] ctrl_addr = ADDR_W'(`VCRC_CTRL_OFFSET);
  wire [ADDR_W-1:0] stat_addr = ADDR_W'(`VCRC_STAT_OFFSET);
  wire hit_cap = (paddr == cap_addr);
  wire hit_ctrl = (paddr == ctrl_addr);
  wire hit_stat = (paddr == stat_addr);
  wire hit_any = hit_cap || hit_ctrl || hit_stat;
  wire access = psel && penable;
  wire wr_ctrl = access && pwrite && hit_ctrl;
  wire wr_b0 = wr_ctrl && pstrb[0];
  wire wr_b2 = wr_ctrl && pstrb[2];
  wire wr_b3 = wr_ctrl && pstrb[3];
  wire [7:1] map_wr = pwdata[7:1];
  wire [7:1] amap_wr = autoload_map[7:1];
  wire [2:0] id_wr = pwdata[`VCRC_CTRL_ID_LSB +: 3];
  wire en_wr = pwdata[`VCRC_CTRL_EN_BIT];

  // --------------------------------------------------------------------------
  // Capability register
  // --------------------------------------------------------------------------
  logic [6:0] slots_reg;
  wire [7:0] cap_arb = strap_reg ? `VCRC_CAP_ARB_RST : 8'h00;
  wire [7:0] cap_tofs = strap_reg ? `VCRC_CAP_TOFS_RST : 8'h00;
  wire [31:0] cap_word = {cap_tofs, 1'b0, slots_reg, 1'b0, 1'b0, 6'h00, cap_arb};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slots_reg <= 7'h00;
    end else if (strap_capture) begin
      slots_reg <= strap_sync ? `VCRC_CAP_SLOT_RST : 7'h00;
    end else if (autoload_valid && strap_reg) begin
      slots_reg <= autoload_slots;
    end
  end

  // --------------------------------------------------------------------------
  // Control register
  // --------------------------------------------------------------------------
  logic [7:1] map_reg;
  logic [2:0] sel_reg;
  logic [2:0] id_reg;
  logic en_reg;
  wire [2:0] sel_wr = pwdata[`VCRC_CTRL_SEL_LSB +: 3];
  wire sel_legal = (sel_wr == 3'h0) || (sel_wr == 3'h3) || (sel_wr == 3'h4);
  wire [2:0] sel_next = sel_legal ? sel_wr : 3'h0;
  wire load_strobe = wr_b2 && pwdata[`VCRC_CTRL_LOAD_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      map_reg <= 7'h00;
      sel_reg <= 3'h0;
      id_reg <= 3'h0;
      en_reg <= 1'b0;
    end else begin
      if (strap_capture) begin
        id_reg <= strap_sync ? `VCRC_CTRL_ID_RST : 3'h0;
      end else if (wr_b3) begin
        id_reg <= pwdata[`VCRC_CTRL_ID_LSB +: 3];
      end
      if (wr_b0) begin
        map_reg <= pwdata[7:1];
      end else if (autoload_valid) begin
        map_reg <= autoload_map[7:1];
      end
      if (wr_b2) begin
        sel_reg <= sel_next;
      end
      if (wr_b3) begin
        en_reg <= pwdata[`VCRC_CTRL_EN_BIT] && strap_reg;
      end
    end
  end

  wire [31:0] ctrl_word = {en_reg, 4'h0, id_reg, 4'h0, sel_reg, 1'b0, 8'h00, map_reg, 1'b0};

  // --------------------------------------------------------------------------
  // Table load and pending flag
  // --------------------------------------------------------------------------
  logic load_busy;
  logic load_done;
  logic pend_reg;

  vcrc_load_timer #(
    .CYCLES(LOAD_CYCLES)
  ) u_load_timer (
    .pclk(pclk),
    .presetn(presetn),
    .start(load_strobe),
    .busy(load_busy),
    .done(load_done)
  );

  // A table write in the same cycle as the load completion wins, so the new entry is not lost.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_reg <= 1'b0;
    end else if (table_write) begin
      pend_reg <= 1'b1;
    end else if (load_done) begin
      pend_reg <= 1'b0;
    end
  end

  wire [31:0] stat_word = {15'h0000, pend_reg, 16'h0000};

  // --------------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------------
  logic [31:0] rdata_reg;
  wire [31:0] rdata_next = hit_cap ? cap_word : hit_ctrl ? ctrl_word : hit_stat ? stat_word : 32'h0000_0000;
  wire rd_take = psel && !penable && !pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg <= 32'h0000_0000;
    end else if (rd_take) begin
      rdata_reg <= rdata_next;
    end
  end

  assign prdata = rdata_reg;
  assign pready = 1'b1;
  assign pslverr = access && !hit_any;

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign traffic_class_map = {map_reg, 1'b0};
  assign arb_scheme = vcrc_pkg::vcrc_arb_e'(sel_reg);
  assign channel_id = id_reg;
  assign channel_enable = en_reg;
  assign table_apply = load_strobe;
  assign table_loading = load_busy;
  assign table_pending = pend_reg;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  // Cycles since the last load strobe, cleared by a table write. It lets the pending clear
  // be checked for any LOAD_CYCLES without a long repetition in a property.
  localparam int SINCE_W = $clog2(LOAD_CYCLES + 3);
  localparam logic [SINCE_W-1:0] SINCE_END = SINCE_W'(LOAD_CYCLES + 2);
  logic [SINCE_W-1:0] since_load_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_load_reg <= '0;
    end else if (load_strobe) begin
      since_load_reg <= SINCE_W'(1);
    end else if (table_write) begin
      since_load_reg <= '0;
    end else if (since_load_reg != '0 && since_load_reg != SINCE_END) begin
      since_load_reg <= since_load_reg + SINCE_W'(1);
    end
  end

  // Traffic class map: bit 0 is never set, and written or autoloaded bits land.
  a_map_bit0: assert property (@(posedge pclk) disable iff (!presetn)
    traffic_class_map[0] == 1'b0) else $error("Map bit 0 became set.");
  a_map_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_b0 |=> traffic_class_map[7:1] == $past(map_wr))
    else $error("Written map bits not stored.");
  a_map_load: assert property (@(posedge pclk) disable iff (!presetn)
    autoload_valid && !wr_b0 |=> traffic_class_map[7:1] == $past(amap_wr))
    else $error("Autoloaded map bits not stored.");

  // Load strobe: never read back, starts one load and lasts one cycle.
  a_load_reads_zero: assert property (@(posedge pclk) disable iff (!presetn)
    rd_take && hit_ctrl |=> prdata[`VCRC_CTRL_LOAD_BIT] == 1'b0) else $error("Load bit read as one.");
  a_load_busy: assert property (@(posedge pclk) disable iff (!presetn)
    load_strobe |=> table_loading)
    else $error("Table load did not start.");
  a_apply_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    table_apply |=> !table_apply)
    else $error("Table apply lasted more than one cycle.");

  // Arbitration select: only legal codes are stored, and they hold between writes.
  a_sel_legal: assert property (@(posedge pclk) disable iff (!presetn)
    wr_b2 && !sel_legal |=> sel_reg == 3'h0) else $error("Illegal select was stored.");
  a_sel_store: assert property (@(posedge pclk) disable iff (!presetn)
    wr_b2 && sel_legal |=> sel_reg == $past(sel_wr)) else $error("Legal select not stored.");
  a_sel_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_b2 |=> $stable(sel_reg))
    else $error("Select changed without a write.");

  // Identifier and enable follow the strap and the bus.
  a_id_strap: assert property (@(posedge pclk) disable iff (!presetn)
    strap_capture && strap_sync |=> channel_id == `VCRC_CTRL_ID_RST)
    else $error("Strapped channel identifier wrong.");
  a_id_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_b3 && !strap_capture |=> channel_id == $past(id_wr))
    else $error("Written channel identifier not stored.");
  a_en_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_b3 && strap_reg |=> channel_enable == $past(en_wr))
    else $error("Written enable not stored.");
  a_enable_absent: assert property (@(posedge pclk) disable iff (!presetn)
    strap_taken_reg && !strap_reg |-> !channel_enable) else $error("Absent channel enabled.");

  // Capability word: fixed, strapped or absent, and never changed by a bus write.
  a_cap_fixed: assert property (@(posedge pclk) disable iff (!presetn)
    cap_word[15:8] == 8'h00 && cap_word[23] == 1'b0) else $error("Capability reserved bits set.");
  a_cap_strap: assert property (@(posedge pclk) disable iff (!presetn)
    strap_reg |-> cap_word[7:0] == 8'h19 && cap_word[31:24] == 8'h08) else $error("Strapped capability wrong.");
  a_cap_absent: assert property (@(posedge pclk) disable iff (!presetn)
    strap_taken_reg && !strap_reg |-> cap_word == 32'h0000_0000)
    else $error("Absent channel reports capabilities.");
  a_cap_ro: assert property (@(posedge pclk) disable iff (!presetn)
    access && pwrite && hit_cap && !autoload_valid && !strap_capture |=> $stable(cap_word))
    else $error("Capability changed by a bus write.");
  a_slots_strap: assert property (@(posedge pclk) disable iff (!presetn)
    strap_capture && strap_sync |=> slots_reg == `VCRC_CAP_SLOT_RST)
    else $error("Strapped time-slot count wrong.");
  a_slots_load: assert property (@(posedge pclk) disable iff (!presetn)
    autoload_valid && strap_reg && !strap_capture |=> slots_reg == $past(autoload_slots))
    else $error("Autoloaded time-slot count not stored.");

  // Pending flag: a table write sets it and a finished load clears it.
  a_pend_set: assert property (@(posedge pclk) disable iff (!presetn)
    table_write |=> pend_reg) else $error("Pending flag not set by table write.");
  a_pend_clear: assert property (@(posedge pclk) disable iff (!presetn)
    since_load_reg == SINCE_END |-> !pend_reg)
    else $error("Pending flag not cleared after load.");
  a_busy_end: assert property (@(posedge pclk) disable iff (!presetn)
    since_load_reg == SINCE_END |-> !table_loading)
    else $error("Table load did not finish in time.");

  // Reserved bits and unmapped addresses.
  a_ctrl_resv: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_word[15:8] == 8'h00 && ctrl_word[30:27] == 4'h0) else $error("Control reserved bits set.");
  a_stat_resv: assert property (@(posedge pclk) disable iff (!presetn)
    stat_word[31:17] == 15'h0000 && stat_word[15:0] == 16'h0000)
    else $error("Status reserved bits set.");
  a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    access && !pwrite && !hit_any |-> pslverr && prdata == 32'h0000_0000)
    else $error("Unmapped read not refused.");
  a_err_mapped: assert property (@(posedge pclk) disable iff (!presetn)
    access && hit_any |-> !pslverr)
    else $error("Mapped access answered with an error.");

endmodule : vcrc_regs

// [bench/vcrc_regs_tb_top.sv]
// Purpose: Self-checking bench for the second channel capability and control registers.
// Assumes: APB master in the bench, a behavioural model of the register pair, one 50 MHz clock.
// Notes: The table load count is shortened to two cycles so that a load finishes quickly.
`timescale 1ns/10ps
`include "vcrc_defines.svh"
module vcrc_regs_tb_top;
  // ---------------------------------------------------------------------------
  // Signals and model state
  // ---------------------------------------------------------------------------
  logic pclk, presetn, psel, penable, pwrite, strap_present, autoload_valid, table_write;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, d;
  logic [3:0] pstrb;
  logic pready, pslverr, err, apply_seen, seen_load;
  logic [6:0] autoload_slots, m_slots;
  logic [7:0] autoload_map, traffic_class_map, m_map;
  vcrc_pkg::vcrc_arb_e arb_scheme;
  logic [2:0] channel_id, m_sel, m_id;
  logic channel_enable, table_apply, table_loading, table_pending, m_en;
  logic [15:0] lfsr;
  int fail_count, n_checks;

  vcrc_regs #(.ADDR_W(12), .LOAD_CYCLES(2)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .strap_present(strap_present), .autoload_valid(autoload_valid),
    .autoload_slots(autoload_slots), .autoload_map(autoload_map), .table_write(table_write),
    .traffic_class_map(traffic_class_map), .arb_scheme(arb_scheme), .channel_id(channel_id),
    .channel_enable(channel_enable), .table_apply(table_apply), .table_loading(table_loading),
    .table_pending(table_pending)
  );

  always #10 pclk = ~pclk;

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  function automatic logic [31:0] exp_cap();
    if (strap_present !== 1'b1) return 32'h0000_0000;
    return {8'h08, 1'b0, m_slots, 16'h0019};
  endfunction : exp_cap

  function automatic logic [31:0] exp_ctrl();
    return {m_en, 4'h0, m_id, 4'h0, m_sel, 1'b0, 8'h00, m_map};
  endfunction : exp_ctrl

  task automatic summarize();
    if (fail_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      fail_count++;
    end
  endtask : chk

  // Entered just after a rising edge; leaves the bus idle one edge later.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk("pready", 32'h0, 32'h1);
    rd = prdata;
    err = pslverr;
    apply_seen = table_apply;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic check_all();
    apb(1'b0, `VCRC_CAP_OFFSET, 32'h0);
    chk("cap", rd, exp_cap());
    chk("cap_err", {31'h0, err}, 32'h0);
    apb(1'b0, `VCRC_CTRL_OFFSET, 32'h0);
    chk("ctrl", rd, exp_ctrl());
    chk("map_out", {24'h0, traffic_class_map}, {24'h0, m_map});
    chk("arb_out", {29'h0, arb_scheme}, {29'h0, m_sel});
    chk("id_out", {29'h0, channel_id}, {29'h0, m_id});
    chk("en_out", {31'h0, channel_enable}, {31'h0, m_en});
  endtask : check_all

  task automatic do_reset(input logic s);
    presetn <= 1'b0;
    strap_present <= s;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (10) @(posedge pclk);
    m_map = 8'h00;
    m_sel = 3'h0;
    m_id = s ? 3'h1 : 3'h0;
    m_en = 1'b0;
    m_slots = s ? 7'h7F : 7'h00;
  endtask : do_reset

  task automatic wr_ctrl(input logic [31:0] wd);
    apb(1'b1, `VCRC_CTRL_OFFSET, wd);
    m_map = {wd[7:1], 1'b0};
    m_sel = (wd[19:17] == 3'h3 || wd[19:17] == 3'h4) ? wd[19:17] : 3'h0;
    m_id = wd[26:24];
    m_en = strap_present & wd[31];
    check_all();
  endtask : wr_ctrl

  task automatic autoload();
    lfsr = lfsr_next(lfsr);
    autoload_valid <= 1'b1;
    autoload_slots <= lfsr[6:0];
    autoload_map <= lfsr[15:8];
    @(posedge pclk);
    autoload_valid <= 1'b0;
    @(posedge pclk);
    if (strap_present) m_slots = lfsr[6:0];
    m_map = {lfsr[15:9], 1'b0};
    check_all();
  endtask : autoload

  // ---------------------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, autoload_valid, table_write} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
    strap_present = 1'b1;
    autoload_slots = 7'h00;
    autoload_map = 8'h00;
    lfsr = 16'd38;
    do_reset(1'b1);
    check_all();
    apb(1'b1, `VCRC_CAP_OFFSET, 32'hFFFF_FFFF);
    check_all();
    for (int s = 0; s < 8; s++) begin
      lfsr = lfsr_next(lfsr);
      d = {lfsr, lfsr};
      d[19:17] = s[2:0];
      d[16] = 1'b0;
      d[31] = s[0];
      wr_ctrl(d);
    end
    d = ~exp_ctrl();
    pstrb <= 4'h1;
    apb(1'b1, `VCRC_CTRL_OFFSET, d);
    pstrb <= 4'hF;
    m_map = {d[7:1], 1'b0};
    check_all();
    apb(1'b0, `VCRC_TBLW_OFFSET, 32'h0);
    chk("unmapped_err", {31'h0, err}, 32'h1);
    chk("unmapped_data", rd, 32'h0);
    table_write <= 1'b1;
    @(posedge pclk);
    table_write <= 1'b0;
    @(posedge pclk);
    chk("pending_set", {31'h0, table_pending}, 32'h1);
    apb(1'b0, `VCRC_STAT_OFFSET, 32'h0);
    chk("status", rd, 32'h0001_0000);
    apb(1'b1, `VCRC_CTRL_OFFSET, exp_ctrl() | 32'h0001_0000);
    chk("apply", {31'h0, apply_seen}, 32'h1);
    seen_load = table_loading;
    for (int n = 0; n < 40 && table_pending !== 1'b0; n++) begin
      @(posedge pclk);
      seen_load = seen_load | table_loading;
    end
    chk("loading", {31'h0, seen_load}, 32'h1);
    chk("pending_clr", {31'h0, table_pending}, 32'h0);
    check_all();
    autoload();
    do_reset(1'b0);
    check_all();
    wr_ctrl(32'hFFFF_FFFF);
    autoload();
    summarize();
  end

  // The whole sequence needs well under a thousand cycles.
  initial begin
    #(20 * 5000);
    fail_count++;
    summarize();
  end
endmodule : vcrc_regs_tb_top
